// ===== rtl/adc_serial_defs.svh
// Constants of the converter serial output port: counts, field positions, offsets, reset values.
`ifndef ADC_SERIAL_DEFS_SVH
`define ADC_SERIAL_DEFS_SVH

// Conversion word and frame layout.
`define ASP_WORD_BITS        16
`define ASP_FRAME_BITS       22
`define ASP_SYNC_FRAME_LAST  5'h0f
`define ASP_UART_FRAME_LAST  5'h15

// Timing counts in master clock cycles.
`define ASP_CAL_HOLD_CYCLES  3'h4
`define ASP_LOAD_CYCLES      3'h4
`define ASP_SCLK_HIGH_PHASE  2'h0
`define ASP_SCLK_FALL_PHASE  2'h1
`define ASP_CAL_WORK_CYCLES  64

// Register offsets.
`define ASP_REG_STATUS       8'h00
`define ASP_REG_CLEAR        8'h04
`define ASP_REG_ENABLE       8'h08
`define ASP_REG_STATE        8'h0c
`define ASP_REG_WORD         8'h10

// Event bit positions and event count.
`define ASP_EV_LOADED        0
`define ASP_EV_SENT          1
`define ASP_EV_CAL_DONE      2
`define ASP_EV_OVERRUN       3
`define ASP_EV_BITS          4

// Reset values.
`define ASP_ENABLE_RESET     4'h0
`define ASP_SYNC_RESET       7'h02

`endif

// ===== rtl/adc_serial_pkg.sv
// Types shared by the converter serial output port.
package adc_serial_pkg;

  typedef enum logic [1:0] {
    UART_STYLE_MODE        = 2'b00,
    EXTERNAL_CLOCKED_MODE  = 2'b01,
    SELF_CLOCKED_MODE      = 2'b10,
    RESERVED_MODE          = 2'b11
  } serial_mode_e;

  typedef enum logic [1:0] {
    CAL_RUN   = 2'b00,
    CAL_HELD  = 2'b01,
    CAL_WORK  = 2'b10
  } cal_state_e;

  typedef enum logic {
    XFER_IDLE  = 1'b0,
    XFER_SHIFT = 1'b1
  } xfer_state_e;

endpackage : adc_serial_pkg

// ===== rtl/pin_sync.sv
// Three-stage synchroniser whose output follows once the second and third stages agree.
`timescale 1ns/100ps
module pin_sync #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  wire  [WIDTH-1:0] agree = ~(stage2_q ^ stage3_q);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
      stage3_q <= RESET_VAL;
      pinOut   <= RESET_VAL;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      pinOut   <= (agree & stage3_q) | (~agree & pinOut);
    end
  end

endmodule : pin_sync

// ===== rtl/port_regs.sv
// Register port with sticky event status, write-one clear, enable mask and level interrupt.
`timescale 1ns/100ps
`include "adc_serial_defs.svh"
module port_regs (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic [7:0]              addr,
  input  wire logic [31:0]             wrData,
  input  wire logic                    wrStrobe,
  input  wire logic                    rdStrobe,
  output logic      [31:0]             rdData,
  input  wire logic [`ASP_EV_BITS-1:0] events,
  input  wire logic [7:0]              stateView,
  input  wire logic [15:0]             wordView,
  output logic                         irq
);

  logic [`ASP_EV_BITS-1:0] status_q;
  logic [`ASP_EV_BITS-1:0] enable_q;

  wire selStatus = addr == `ASP_REG_STATUS;
  wire selClear  = addr == `ASP_REG_CLEAR;
  wire selEnable = addr == `ASP_REG_ENABLE;
  wire selState  = addr == `ASP_REG_STATE;
  wire selWord   = addr == `ASP_REG_WORD;
  wire [`ASP_EV_BITS-1:0] clearBits = (wrStrobe && selClear) ? wrData[`ASP_EV_BITS-1:0] : '0;
  // A new event outranks a clear of the same bit in the same cycle.
  wire [`ASP_EV_BITS-1:0] status_d = (status_q & ~clearBits) | events;
  wire [31:0] readMux =
      selStatus ? {28'h0000000, status_q} :
      selEnable ? {28'h0000000, enable_q} :
      selState  ? {24'h000000, stateView} :
      selWord   ? {16'h0000, wordView} : 32'h00000000;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= '0;
      enable_q <= `ASP_ENABLE_RESET;
      rdData   <= 32'h00000000;
      irq      <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wrStrobe && selEnable) begin
        enable_q <= wrData[`ASP_EV_BITS-1:0];
      end
      rdData <= rdStrobe ? readMux : 32'h00000000;
      irq    <= |(status_d & enable_q);
    end
  end

endmodule : port_regs

// ===== rtl/adc_serial_output_port.sv
// Serial output port of a sigma-delta converter: calibration strobe, word hand-off, framing.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "adc_serial_defs.svh"
module adc_serial_output_port
  import adc_serial_pkg::*;
#(
  parameter int CAL_WORK_CYCLES = `ASP_CAL_WORK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [1:0]  serialModeSel,
  input  wire logic        calStrobe,
  input  wire logic        cal_type_sel_a,
  input  wire logic        cal_type_sel_b,
  input  wire logic        chipSelectN,
  input  wire logic        sclkIn,
  output logic             sclkOut,
  output logic             sclkOutEn,
  output logic             serial_out,
  output logic             serialOutEn,
  output logic             word_valid_n,
  input  wire logic [15:0] newWord,
  input  wire logic        newWordLoad,
  output logic             calBusy,
  output logic [1:0]       calType,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStrobe,
  input  wire logic        regRdStrobe,
  output logic [31:0]      regRdData,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [6:0]   syncOut;
  logic         calPrev_q;
  logic         csPrev_q;
  logic         sclkPrev_q;

  pin_sync #(
    .WIDTH     (7),
    .RESET_VAL (`ASP_SYNC_RESET)
  ) u_pin_sync (
    .clock  (clock),
    .resetn (resetn),
    .pinIn  ({serialModeSel, cal_type_sel_b, cal_type_sel_a, sclkIn, chipSelectN, calStrobe}),
    .pinOut (syncOut)
  );

  wire          calS  = syncOut[0];
  wire          csNS  = syncOut[1];
  wire          sclkS = syncOut[2];
  wire [1:0]    selS  = syncOut[4:3];
  serial_mode_e modeS;
  assign modeS = serial_mode_e'(syncOut[6:5]);

  // Edge memories start at chip select high and link clock low, so reset never fakes a fall.
  wire calRise  = calS & ~calPrev_q;
  wire csFall   = ~csNS & csPrev_q;
  wire sclkFall = ~sclkS & sclkPrev_q;
  wire selfClk  = modeS == SELF_CLOCKED_MODE;
  wire uartMode = modeS == UART_STYLE_MODE;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Calibration strobe: hold detection, internal reset and calibration cycle.

  cal_state_e   calState_q;
  cal_state_e   calState_d;
  logic [2:0]   holdCnt_q;
  logic [31:0]  workCnt_q;
  logic [1:0]   calType_q;

  wire holdDone = calS && (holdCnt_q == `ASP_CAL_HOLD_CYCLES);
  wire workDone = (calState_q == CAL_WORK) && (workCnt_q == 32'(CAL_WORK_CYCLES - 1));
  wire inReset  = calState_q != CAL_RUN;

  always_comb begin
    calState_d = calState_q;
    case (calState_q)
      CAL_RUN: begin
        if (holdDone) begin
          calState_d = CAL_HELD;
        end
      end
      CAL_HELD: begin
        if (!calS) begin
          calState_d = CAL_WORK;
        end
      end
      CAL_WORK: begin
        if (calS && holdDone) begin
          calState_d = CAL_HELD;
        end else if (workDone) begin
          calState_d = CAL_RUN;
        end
      end
      default: calState_d = CAL_RUN;
    endcase
  end

  // Every step below is a fixed count from the synchronised strobe edge, so converters that
  // share the strobe and master clock leave calibration on the same cycle.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      calState_q <= CAL_RUN;
      holdCnt_q  <= 3'h0;
      workCnt_q  <= 32'h00000000;
      calType_q  <= 2'h0;
      calPrev_q  <= 1'b0;
    end else begin
      calState_q <= calState_d;
      calPrev_q  <= calS;
      // A strobe that returns during calibration starts the hold count afresh.
      holdCnt_q  <= !calS ? 3'h0 : (holdDone ? holdCnt_q : holdCnt_q + 3'h1);
      workCnt_q  <= (calState_q == CAL_WORK && !workDone) ? workCnt_q + 32'h1 : 32'h0;
      if (calRise) begin
        calType_q <= selS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Output register load and data-ready.

  logic [2:0]   loadCnt_q;
  logic [15:0]  pendWord_q;
  logic [15:0]  outWord_q;
  logic         wordAvail_q;
  logic         wordAvail_d;
  xfer_state_e  xfer_q;
  logic [4:0]   bitCnt_q;
  logic [21:0]  frame_q;
  logic [1:0]   divCnt_q;

  // Loads arriving during reset or calibration are dropped, keeping data-ready high.
  wire loadStart = newWordLoad && !inReset;
  // A load during a load restarts the four-cycle count, so the last word taken is shown.
  wire loadEnd   = (loadCnt_q == 3'h1) && !inReset;
  wire shifting  = xfer_q == XFER_SHIFT;
  wire shiftTick = selfClk ? (divCnt_q == `ASP_SCLK_FALL_PHASE) : sclkFall;
  wire lastBit   = shifting && !csNS && shiftTick && (bitCnt_q == 5'h00);
  wire xferStart = !shifting && csFall && !inReset;
  wire [4:0] frameLast = uartMode ? `ASP_UART_FRAME_LAST : `ASP_SYNC_FRAME_LAST;

  always_comb begin
    wordAvail_d = wordAvail_q;
    if (inReset || loadStart) begin
      wordAvail_d = 1'b0;
    end else if (loadEnd) begin
      wordAvail_d = 1'b1;
    end else if (lastBit) begin
      wordAvail_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      loadCnt_q    <= 3'h0;
      pendWord_q   <= 16'h0000;
      outWord_q    <= 16'h0000;
      wordAvail_q  <= 1'b0;
      word_valid_n <= 1'b1;
    end else begin
      if (inReset) begin
        loadCnt_q <= 3'h0;
      end else if (loadStart) begin
        loadCnt_q  <= `ASP_LOAD_CYCLES;
        pendWord_q <= newWord;
      end else if (loadCnt_q != 3'h0) begin
        loadCnt_q <= loadCnt_q - 3'h1;
      end
      if (loadEnd) begin
        outWord_q <= pendWord_q;
      end
      wordAvail_q  <= wordAvail_d;
      word_valid_n <= ~wordAvail_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Framing and shifting.

  // Puts a byte into transmit order, least significant bit first.
  function automatic logic [7:0] lsbFirst(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[7 - i] = b[i];
    end
    return r;
  endfunction : lsbFirst

  // High byte travels first; each byte carries a start bit and two stop bits.
  wire [21:0] uartFrame = {1'b0, lsbFirst(outWord_q[15:8]), 2'b11,
                           1'b0, lsbFirst(outWord_q[7:0]), 2'b11};
  wire [21:0] syncFrame = {outWord_q, 6'h3f};
  wire [21:0] startFrame = uartMode ? uartFrame : syncFrame;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      xfer_q     <= XFER_IDLE;
      bitCnt_q   <= 5'h00;
      frame_q    <= 22'h3fffff;
      divCnt_q   <= 2'h0;
      csPrev_q   <= 1'b1;
      sclkPrev_q <= 1'b0;
    end else begin
      csPrev_q   <= csNS;
      sclkPrev_q <= sclkS;
      divCnt_q   <= shifting ? divCnt_q + 2'h1 : 2'h0;
      case (xfer_q)
        XFER_IDLE: begin
          if (xferStart) begin
            xfer_q   <= XFER_SHIFT;
            frame_q  <= startFrame;
            bitCnt_q <= frameLast;
          end
        end
        XFER_SHIFT: begin
          if (csNS || inReset) begin
            // A cut frame parks the shift register at the idle mark.
            xfer_q  <= XFER_IDLE;
            frame_q <= 22'h3fffff;
          end else if (shiftTick) begin
            frame_q  <= {frame_q[20:0], 1'b1};
            bitCnt_q <= bitCnt_q - 5'h01;
            if (bitCnt_q == 5'h00) begin
              xfer_q <= XFER_IDLE;
            end
          end
        end
        default: xfer_q <= XFER_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sclkOut     <= 1'b0;
      sclkOutEn   <= 1'b0;
      serial_out  <= 1'b1;
      serialOutEn <= 1'b0;
      calBusy     <= 1'b0;
      calType     <= 2'h0;
    end else begin
      sclkOutEn   <= selfClk;
      sclkOut     <= selfClk && shifting && !csNS
                     && (divCnt_q == `ASP_SCLK_HIGH_PHASE);
      // Outside a live frame, a cut one included, the data line rests at its idle mark.
      serial_out  <= (shifting && !csNS) ? frame_q[21] : 1'b1;
      serialOutEn <= shifting && !csNS;
      calBusy     <= inReset;
      calType     <= calType_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt.

  wire [`ASP_EV_BITS-1:0] events;
  assign events[`ASP_EV_LOADED]   = loadEnd;
  assign events[`ASP_EV_SENT]     = lastBit;
  assign events[`ASP_EV_CAL_DONE] = workDone && !calS;
  // Overrun marks a load that lands on a word the host has not yet shifted out.
  assign events[`ASP_EV_OVERRUN]  = loadStart && wordAvail_q;

  port_regs u_port_regs (
    .clock     (clock),
    .resetn    (resetn),
    .addr      (regAddr),
    .wrData    (regWrData),
    .wrStrobe  (regWrStrobe),
    .rdStrobe  (regRdStrobe),
    .rdData    (regRdData),
    .events    (events),
    .stateView ({modeS, calType_q, shifting, calState_q, wordAvail_q}),
    .wordView  (outWord_q),
    .irq       (irq)
  );

endmodule : adc_serial_output_port

// ===== verif/adc_serial_output_port_monitor.sv
// Checker of the converter serial output port.
`timescale 1ns/100ps
module adc_serial_output_port_monitor
  import adc_serial_pkg::*;
#(
  parameter int CAL_WORK_CYCLES = 64
) (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [1:0] serialModeSel,
  input wire logic       calStrobe,
  input wire logic       chipSelectN,
  input wire logic       sclkOut,
  input wire logic       sclkOutEn,
  input wire logic       serial_out,
  input wire logic       serialOutEn,
  input wire logic       word_valid_n,
  input wire logic       newWordLoad,
  input wire logic       calBusy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [7:0] calCnt_q;
  // Counts calibration cycles once the strobe has gone low.
  always_ff @(posedge clock) begin
    if (!calBusy || calStrobe) calCnt_q <= 8'h00;
    else if (calCnt_q != 8'hff) calCnt_q <= calCnt_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_CAL_ENTRY: assert property ($rose(calBusy) |-> $past(calStrobe, 5) && $past(calStrobe, 8))
    else $error("calibration began without a long strobe");
  AST_CAL_HOLD: assert property (calBusy && calStrobe |=> calBusy)
    else $error("calibration ended while the strobe was high");
  AST_CAL_LEN: assert property ($fell(calBusy) |-> calCnt_q >= CAL_WORK_CYCLES)
    else $error("calibration too short");
  AST_CAL_WORD_VALID_N: assert property (calBusy |-> word_valid_n)
    else $error("data ready low during calibration");
  AST_LOAD_HIGH: assert property (newWordLoad && !calBusy |=> word_valid_n [*4])
    else $error("data ready not held high during load");
  AST_LOAD_LOW: assert property ((newWordLoad && !calBusy && chipSelectN) ##1
    (!newWordLoad && !calBusy && chipSelectN) [*4] |=> !word_valid_n)
    else $error("data ready not low after load");
  AST_SENT_HIGH: assert property ($fell(serialOutEn) && !chipSelectN && !$past(chipSelectN, 4)
    |-> ##[0:1] word_valid_n)
    else $error("data ready not high after word sent");
  AST_CS_START: assert property ($fell(chipSelectN) && !serialOutEn && !calBusy
    |-> ##[2:10] serialOutEn)
    else $error("transfer did not start on chip select");
  AST_SCLK_OUT: assert property ((serialModeSel == SELF_CLOCKED_MODE) [*8] |-> sclkOutEn)
    else $error("serial clock not an output in self clocked mode");
  AST_SCLK_IN: assert property ((serialModeSel != SELF_CLOCKED_MODE) [*8] |-> !sclkOutEn)
    else $error("serial clock driven outside self clocked mode");
  AST_SCLK_DUTY: assert property ($rose(sclkOut) |=> !sclkOut [*3])
    else $error("serial clock duty wrong");
  AST_SCLK_EN: assert property (sclkOut |-> sclkOutEn)
    else $error("serial clock high while not driven");
  AST_IDLE_MARK: assert property (!serialOutEn |-> serial_out)
    else $error("serial data not idle high");
  cover property ($rose(calBusy));
  cover property ($fell(serialOutEn) && !chipSelectN);
  cover property ($rose(sclkOut));
endmodule : adc_serial_output_port_monitor

// ===== verif/host_serial_model.sv
// Host serial port model that frames a transfer and collects the bits.
`timescale 1ns/100ps
module host_serial_model (
  input  wire logic clock,
  input  wire logic serial_out,
  input  wire logic sclkOut,
  output logic      chipSelectN,
  output logic      sclkIn
);
  initial begin
    chipSelectN = 1'b1;
    sclkIn      = 1'b1;
  end
  // The link clock stands high between frames and runs at 32 ns inside frames that the host clocks, staying high in self clocked ones.
  task automatic frame(input int nBits, input logic selfClk, output logic [21:0] got);
    int w;
    got = '0;
    @(posedge clock);
    chipSelectN <= 1'b0;
    repeat (selfClk ? 2 : 10) @(posedge clock);
    #1;
    for (int i = 0; i < nBits; i++) begin
      if (selfClk) begin
        w = 0;
        while (sclkOut !== 1'b1 && w < 100) begin
          @(posedge clock);
          #1;
          w++;
        end
        got = {got[20:0], serial_out};
        @(posedge clock);
        #1;
      end else begin
        got = {got[20:0], serial_out};
        @(posedge clock);
        sclkIn <= 1'b0;
        repeat (4) @(posedge clock);
        sclkIn <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
      end
    end
    repeat (8) @(posedge clock);
    chipSelectN <= 1'b1;
  endtask : frame
endmodule : host_serial_model

// ===== verif/tb_adc_serial_output_port.sv
// Testbench of the converter serial output port.
`timescale 1ns/100ps
module tb_adc_serial_output_port
  import adc_serial_pkg::*;
();
  localparam int CAL_WORK_CYCLES = 8;
  logic        clock, resetn, calStrobe, cal_type_sel_a, cal_type_sel_b, newWordLoad;
  logic        regWrStrobe, regRdStrobe;
  logic [1:0]  serialModeSel;
  logic [7:0]  regAddr;
  logic [15:0] newWord;
  logic [31:0] regWrData;
  wire         chipSelectN, sclkIn, sclkOut, sclkOutEn, serial_out, serialOutEn;
  wire         word_valid_n, calBusy, irq;
  wire  [1:0]  calType;
  wire  [31:0] regRdData;
  int          nErrors, nCompared, cycles, w;

  adc_serial_output_port #(.CAL_WORK_CYCLES(CAL_WORK_CYCLES)) adc_serial_output_port_i (
    .clock(clock), .resetn(resetn), .serialModeSel(serialModeSel), .calStrobe(calStrobe),
    .cal_type_sel_a(cal_type_sel_a), .cal_type_sel_b(cal_type_sel_b),
    .chipSelectN(chipSelectN), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOutEn(sclkOutEn),
    .serial_out(serial_out), .serialOutEn(serialOutEn), .word_valid_n(word_valid_n),
    .newWord(newWord), .newWordLoad(newWordLoad), .calBusy(calBusy), .calType(calType),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .irq(irq));
  host_serial_model host_serial_model_i (
    .clock(clock), .serial_out(serial_out), .sclkOut(sclkOut),
    .chipSelectN(chipSelectN), .sclkIn(sclkIn));

  initial clock = 1'b0;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      giveVerdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk1(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clock);
    regWrStrobe <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clock);
    regRdStrobe <= 1'b0;
    #1 chk32(regRdData, e);
  endtask : rd
  task automatic strobe(input int n);
    calStrobe <= 1'b1;
    repeat (n) @(posedge clock);
    calStrobe <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
  endtask : strobe
  task automatic loadWord(input logic [15:0] d);
    newWord <= d;
    newWordLoad <= 1'b1;
    @(posedge clock);
    newWordLoad <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk1(word_valid_n, 1'b1);
    repeat (2) @(posedge clock);
    #1 chk1(word_valid_n, 1'b0);
  endtask : loadWord
  task automatic xfer(input logic [1:0] m, input logic [15:0] d);
    logic [21:0] g;
    logic [21:0] e;
    serialModeSel <= m;
    repeat (8) @(posedge clock);
    loadWord(d);
    chk1(sclkOutEn, m == SELF_CLOCKED_MODE);
    e = {6'h00, d};
    if (m == UART_STYLE_MODE) begin
      e = 22'h001803;
      for (int i = 0; i < 8; i++) begin
        e[20-i] = d[8+i];
        e[9-i] = d[i];
      end
    end
    host_serial_model_i.frame((m == UART_STYLE_MODE) ? 22 : 16, m == SELF_CLOCKED_MODE, g);
    chk32({10'h000, g}, {10'h000, e});
    repeat (8) @(posedge clock);
    #1 chk1(word_valid_n, 1'b1);
  endtask : xfer
  task automatic giveVerdict();
    $display("errors %0d compared %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : giveVerdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, calStrobe, cal_type_sel_a, cal_type_sel_b, newWordLoad} = '0;
    {regWrStrobe, regRdStrobe, regAddr, regWrData, newWord} = '0;
    serialModeSel = 2'b01;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (8) @(posedge clock);
    #1 chk1(word_valid_n, 1'b1);
    rd(8'h08, 32'h0);
    rd(8'h20, 32'h0);
    cal_type_sel_a <= 1'b1;
    @(posedge clock);
    strobe(4);
    chk1(calBusy, 1'b0);
    chk32({30'h0, calType}, 32'h1);
    cal_type_sel_a <= 1'b0;
    cal_type_sel_b <= 1'b1;
    @(posedge clock);
    strobe(10);
    chk1(calBusy, 1'b1);
    w = 0;
    while (calBusy !== 1'b0 && w < 100) begin
      @(posedge clock);
      #1;
      w++;
    end
    chk1(w >= CAL_WORK_CYCLES - 6 && w <= CAL_WORK_CYCLES + 4, 1'b1);
    chk1(calBusy, 1'b0);
    chk32({30'h0, calType}, 32'h2);
    chk1(word_valid_n, 1'b1);
    rd(8'h00, 32'h4);
    wr(8'h04, 32'hf);
    wr(8'h08, 32'h1);
    loadWord(16'h1234);
    rd(8'h10, 32'h1234);
    chk1(irq, 1'b1);
    wr(8'h04, 32'h1);
    @(posedge clock);
    #1 chk1(irq, 1'b0);
    wr(8'h08, 32'h0);
    loadWord(16'h0f0f);
    chk1(irq, 1'b0);
    rd(8'h00, 32'h9);
    wr(8'h08, 32'h8);
    @(posedge clock);
    #1 chk1(irq, 1'b1);
    wr(8'h04, 32'hf);
    xfer(2'b01, 16'h8001);
    xfer(2'b11, 16'h7ffe);
    xfer(2'b00, 16'hc35a);
    xfer(2'b10, 16'ha5c3);
    giveVerdict();
  end
endmodule : tb_adc_serial_output_port

bind adc_serial_output_port adc_serial_output_port_monitor #(
  .CAL_WORK_CYCLES(CAL_WORK_CYCLES)
) adc_serial_output_port_monitor_i (
  .clock(clock), .resetn(resetn), .serialModeSel(serialModeSel), .calStrobe(calStrobe),
  .chipSelectN(chipSelectN), .sclkOut(sclkOut), .sclkOutEn(sclkOutEn),
  .serial_out(serial_out), .serialOutEn(serialOutEn), .word_valid_n(word_valid_n),
  .newWordLoad(newWordLoad), .calBusy(calBusy));
